// ---- include/bcob_regs.vh ----
// register offsets, field positions, reset values and decode constants
// for the converter start-up configuration bank
`ifndef BCOB_REGS_VH
`define BCOB_REGS_VH

// printed offsets are register indices; byte address is four times these
`define BCOB_IDX_CONV_TWO    16'h7812
`define BCOB_IDX_CONV_THREE  16'h7813
`define BCOB_ADDR_CONV_TWO   18'h1e048
`define BCOB_ADDR_CONV_THREE 18'h1e04c

`define BCOB_RST_CONV_TWO    16'h0080
`define BCOB_RST_CONV_THREE  16'h0000

// field positions
`define BCOB_SLOT_HI   15
`define BCOB_SLOT_LO   13
`define BCOB_FREQ_HI   9
`define BCOB_FREQ_LO   8
`define BCOB_PHASE_BIT 7
`define BCOB_VSEL_HI   6
`define BCOB_VSEL_LO   0
`define BCOB_CAP_HI    1
`define BCOB_CAP_LO    0

// slot encodings
`define BCOB_SLOT_OFF  3'h0
`define BCOB_SLOT_MAX  3'h5
`define BCOB_SLOT_HW1  3'h6
`define BCOB_SLOT_HW2  3'h7

// switching rate code for 4 MHz
`define BCOB_FREQ_4MHZ 2'h3

// voltages in units of 0.1 mV
`define BCOB_TWO_VMIN     16'h1770
`define BCOB_TWO_VMAX     16'h4650
`define BCOB_TWO_STEP     16'h007d
`define BCOB_TWO_CLAMP_LO 7'h08
`define BCOB_TWO_CLAMP_HI 7'h68
`define BCOB_TWO_4MHZ_MAX 7'h48
`define BCOB_THR_VMIN     16'h2134
`define BCOB_THR_VMAX     16'h84d0
`define BCOB_THR_STEP     16'h00fa
`define BCOB_THR_CLAMP_HI 7'h66

// ahb transfer type
`define BCOB_HTRANS_NONSEQ 2'h2

`endif

// ---- logic/bcob_top.v ----
// converter start-up configuration bank: two 16-bit words on ahb-lite,
// with registered decodes of voltage, slot and phase for the sequencer.
// assumes one ahb-lite master, word accesses, i_clk at 250 MHz.
`timescale 1ns/1ps
`include "bcob_regs.vh"

module bcob_top #(
  parameter AW = 18
) (
  input  wire        i_clk,
  input  wire        i_rstn,
  input  wire        i_ce,
  input  wire        i_hsel,
  input  wire [AW-1:0] i_haddr,
  input  wire [1:0]  i_htrans,
  input  wire        i_hwrite,
  input  wire [2:0]  i_hsize,
  input  wire [31:0] i_hwdata,
  input  wire        i_hready,
  output reg  [31:0] o_hrdata,
  output reg         o_hreadyout,
  output reg         o_hresp,
  output reg  [15:0] o_conv_two_voltage,
  output reg  [1:0]  o_conv_two_capacitor_range,
  output reg         o_conv_two_rate_violation,
  output reg  [15:0] o_conv_three_voltage,
  output reg  [1:0]  o_conv_three_capacitor_range,
  output reg         o_conv_three_clock_phase,
  output reg         o_conv_three_off,
  output reg  [2:0]  o_conv_three_timeslot,
  output reg         o_conv_three_hw_enable1,
  output reg         o_conv_three_hw_enable2
);

  reg  [15:0] conv_two_q;
  reg  [15:0] conv_three_q;
  reg         wr_pend_q;
  reg         wr_sel_two_q;
  reg         wr_sel_thr_q;

  wire        acc = i_hsel & i_hready & (i_htrans == `BCOB_HTRANS_NONSEQ);
  wire        hit_two = (i_haddr == `BCOB_ADDR_CONV_TWO);
  wire        hit_thr = (i_haddr == `BCOB_ADDR_CONV_THREE);

  // forward pending write so a read right behind it sees the new word
  wire [15:0] two_now = (wr_pend_q & wr_sel_two_q) ?
                        i_hwdata[15:0] : conv_two_q;
  wire [15:0] thr_now = (wr_pend_q & wr_sel_thr_q) ?
                        i_hwdata[15:0] : conv_three_q;

  wire [6:0]  two_code = conv_two_q[`BCOB_VSEL_HI:`BCOB_VSEL_LO];
  wire [6:0]  thr_code = conv_three_q[`BCOB_VSEL_HI:`BCOB_VSEL_LO];
  wire [2:0]  thr_slot = conv_three_q[`BCOB_SLOT_HI:`BCOB_SLOT_LO];
  wire [1:0]  two_freq = conv_two_q[`BCOB_FREQ_HI:`BCOB_FREQ_LO];

  reg  [15:0] two_volt_d;
  reg  [15:0] thr_volt_d;
  reg  [6:0]  two_off;

  // fine 12.5 mV / 25 mV steps fall out of the linear decode
  always @*
  begin
    two_off = two_code - `BCOB_TWO_CLAMP_LO;
    if (two_code <= `BCOB_TWO_CLAMP_LO)
      two_volt_d = `BCOB_TWO_VMIN;
    else if (two_code >= `BCOB_TWO_CLAMP_HI)
      two_volt_d = `BCOB_TWO_VMAX;
    else
      two_volt_d = `BCOB_TWO_VMIN +
                   {9'h000, two_off} * `BCOB_TWO_STEP;
    if (thr_code >= `BCOB_THR_CLAMP_HI)
      thr_volt_d = `BCOB_THR_VMAX;
    else
      thr_volt_d = `BCOB_THR_VMIN +
                   {9'h000, thr_code} * `BCOB_THR_STEP;
  end

  always @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      conv_two_q   <= `BCOB_RST_CONV_TWO;
      conv_three_q <= `BCOB_RST_CONV_THREE;
      wr_pend_q    <= 1'b0;
      wr_sel_two_q <= 1'b0;
      wr_sel_thr_q <= 1'b0;
      o_hrdata     <= 32'h00000000;
      o_hreadyout  <= 1'b1;
      o_hresp      <= 1'b0;
    end
    else if (i_ce)
    begin
      // zero-wait slave: always ready, always okay
      o_hreadyout <= 1'b1;
      o_hresp     <= 1'b0;
      if (wr_pend_q & wr_sel_two_q)
        conv_two_q <= i_hwdata[15:0];
      if (wr_pend_q & wr_sel_thr_q)
        conv_three_q <= i_hwdata[15:0];
      wr_pend_q    <= acc & i_hwrite;
      wr_sel_two_q <= acc & i_hwrite & hit_two;
      wr_sel_thr_q <= acc & i_hwrite & hit_thr;
      // unmapped reads return zero
      if (acc & ~i_hwrite)
        o_hrdata <= hit_two ? {16'h0000, two_now} :
                    hit_thr ? {16'h0000, thr_now} : 32'h00000000;
    end
  end

  // decodes lag the stored word by one cycle
  always @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      o_conv_two_voltage           <= `BCOB_TWO_VMIN;
      o_conv_two_capacitor_range   <= 2'h0;
      o_conv_two_rate_violation    <= 1'b0;
      o_conv_three_voltage         <= `BCOB_THR_VMIN;
      o_conv_three_capacitor_range <= 2'h0;
      o_conv_three_clock_phase     <= 1'b0;
      o_conv_three_off             <= 1'b1;
      o_conv_three_timeslot        <= 3'h0;
      o_conv_three_hw_enable1      <= 1'b0;
      o_conv_three_hw_enable2      <= 1'b0;
    end
    else if (i_ce)
    begin
      o_conv_two_voltage   <= two_volt_d;
      o_conv_three_voltage <= thr_volt_d;
      o_conv_two_capacitor_range <=
        conv_two_q[`BCOB_CAP_HI:`BCOB_CAP_LO];
      o_conv_three_capacitor_range <=
        conv_three_q[`BCOB_CAP_HI:`BCOB_CAP_LO];
      // flag only: the device does not enforce the 4 MHz ceiling
      o_conv_two_rate_violation <= (two_freq == `BCOB_FREQ_4MHZ) &
                         (two_code > `BCOB_TWO_4MHZ_MAX);
      o_conv_three_clock_phase <=
        conv_three_q[`BCOB_PHASE_BIT];
      o_conv_three_off <= (thr_slot == `BCOB_SLOT_OFF);
      o_conv_three_timeslot <= (thr_slot <= `BCOB_SLOT_MAX) ?
                               thr_slot : 3'h0;
      o_conv_three_hw_enable1 <= (thr_slot == `BCOB_SLOT_HW1);
      o_conv_three_hw_enable2 <= (thr_slot == `BCOB_SLOT_HW2);
    end
  end

endmodule // bcob_top

// ---- testbench/bcob_monitor.sv ----
// checker on bcob_top output ports, bound in below its endmodule
`timescale 1ns/1ps
module bcob_monitor (
  input wire        i_clk,
  input wire        i_rstn,
  input wire [15:0] o_conv_two_voltage,
  input wire [15:0] o_conv_three_voltage,
  input wire        o_conv_three_off,
  input wire [2:0]  o_conv_three_timeslot
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  two_low_a: assert property (o_conv_two_voltage >= 16'h1770)
    else $error("v2 low");
  two_high_a: assert property (o_conv_two_voltage <= 16'h4650)
    else $error("v2 high");
  two_step_a: assert property
    ((o_conv_two_voltage - 16'h1770) % 16'h007d == 16'h0) else $error("v2");
  thr_low_a: assert property (o_conv_three_voltage >= 16'h2134)
    else $error("v3 low");
  thr_high_a: assert property (o_conv_three_voltage <= 16'h84d0)
    else $error("v3 high");
  thr_step_a: assert property
    ((o_conv_three_voltage - 16'h2134) % 16'h00fa == 16'h0) else $error("v3");
  slot_off_a: assert property
    (o_conv_three_off |-> o_conv_three_timeslot == 3'h0) else $error("off");
  slot_max_a: assert property (o_conv_three_timeslot <= 3'h5)
    else $error("slot");
endmodule // bcob_monitor
bind bcob_top bcob_monitor i_mon (.*);

// ---- testbench/bcob_tb.sv ----
// bench for bcob_top as sole ahb-lite master; hreadyout loops to hready
`timescale 1ns/1ps
`include "bcob_regs.vh"
module tb;
  reg         i_clk = 0, i_rstn = 0;
  reg  [52:0] m = 0; // hwdata, htrans, hwrite, haddr: one write per phase
  wire [31:0] q;
  wire        y, v, p, o, h1, h2, hr;
  wire [1:0]  cr2, cr3;
  wire [15:0] v2, v3;
  wire [2:0]  s;
  integer     bad_count = 0, n_tests = 0, c;
  bcob_top i_dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_ce(1'b1),
    .i_hsel(1'b1), .i_haddr(m[17:0]), .i_htrans(m[20:19]),
    .i_hwrite(m[18]), .i_hsize(3'h2), .i_hwdata(m[52:21]), .i_hready(y),
    .o_hrdata(q), .o_hreadyout(y), .o_hresp(hr), .o_conv_two_voltage(v2),
    .o_conv_two_capacitor_range(cr2), .o_conv_two_rate_violation(v),
    .o_conv_three_voltage(v3), .o_conv_three_capacitor_range(cr3),
    .o_conv_three_clock_phase(p), .o_conv_three_off(o),
    .o_conv_three_timeslot(s), .o_conv_three_hw_enable1(h1),
    .o_conv_three_hw_enable2(h2));
  initial forever #2 i_clk = ~i_clk;
  task xfer(input wr, input [17:0] ad, input [15:0] wd);
    m[20:0] <= {2'h2, wr, ad};
    do @(posedge i_clk); while (y !== 1'b1);
    m[52:19] <= {16'h0, wd, 2'h0};
    do @(posedge i_clk); while (y !== 1'b1);
  endtask
  task chk(input [31:0] g, input [31:0] x);
    n_tests = n_tests + 1;
    bad_count = bad_count + (g !== x);
    if (g !== x)
      $display("Error %0t: got %h want %h", $time, g, x);
  endtask
  task conclude;
    $display("%0d checks, %0d mismatches", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    repeat (16) @(posedge i_clk);
    chk({v2[14:0], v3[14:0], o, p}, {15'h1770, 15'h2134, 2'h2});
    i_rstn <= 1'b1;
    xfer(0, `BCOB_ADDR_CONV_TWO, 0);
    chk(q, 32'h80);
    xfer(0, 18'h1e050, 0);
    chk(q, 0);
    for (c = 0; c < 128; c = c + 1)
    begin
      xfer(1, `BCOB_ADDR_CONV_TWO, {6'h0, c[0], c[0], 1'b1, c[6:0]});
      xfer(1, `BCOB_ADDR_CONV_THREE, {c[2:0], 5'h0, c[3], c[6:0]});
      xfer(0, `BCOB_ADDR_CONV_THREE, 0);
      chk(q, {16'h0, c[2:0], 5'h0, c[3], c[6:0]});
      repeat (2) @(posedge i_clk);
      chk({cr2, cr3, hr}, {c[1:0], c[1:0], 1'b0});
      chk(v2, c < 9 ? 6000 : c > 103 ? 18000 : 5000 + c * 125);
      chk(v3, c > 101 ? 34000 : 8500 + c * 250);
      chk({v, p}, {c[0] && c > 72, c[3]});
      chk({o, s, h1, h2}, {c[2:0] == 0, c[2:0] < 6 ? c[2:0] : 3'h0,
        c[2:0] == 6, c[2:0] == 7});
    end
    $display("test done: reset, unmapped read, decode sweep");
    conclude;
  end
  initial
  begin
    #20000;
    bad_count = bad_count + 1;
    conclude;
  end
endmodule // tb
